// ### spl_shift_latch.v
// shift register with storage register, pins oversampled on MCLK
// assumes pin clocks are far slower than MCLK (high and low each >= 2 cycles)
`timescale 1ns/1ps
`include "spl_consts.vh"
module spl_shift_latch (
	input  wire                  MCLK,
	input  wire                  RESET,
	input  wire                  SERIAL_IN,
	input  wire                  SHIFT_CLOCK,
	input  wire                  STORAGE_CLOCK,
	input  wire                  SHIFT_CLEAR_N,
	input  wire                  STORAGE_CLEAR_N,
	output reg  [`SPL_WIDTH-1:0] PARALLEL_OUT,
	output reg                   CASCADE_OUT,
	output wire [`SPL_WIDTH-1:0] LOG_DATA,
	output wire                  LOG_VALID,
	input  wire                  LOG_READY,
	output wire                  LOG_ACCEPT
);
	reg  [`SPL_PIN_COUNT-1:0] sync1_r;
	reg  [`SPL_PIN_COUNT-1:0] sync2_r;
	reg                       sclk_prev_r;
	reg                       rclk_prev_r;
	reg  [`SPL_WIDTH-1:0]     shift_r;
	reg  [`SPL_WIDTH-1:0]     shift_nxt;
	reg  [`SPL_WIDTH-1:0]     store_r;
	reg  [`SPL_WIDTH-1:0]     store_nxt;
	wire                      shift_rise;
	wire                      store_rise;
	wire                      shift_clr;
	wire                      store_clr;
	wire                      log_push;

	// two-stage pin synchroniser; first stage feeds only the second
	always @(posedge MCLK) begin
		if (RESET) begin
			sync1_r <= `SPL_PIN_RESET;
			sync2_r <= `SPL_PIN_RESET;
		end else begin
			sync1_r <= {STORAGE_CLEAR_N, SHIFT_CLEAR_N, STORAGE_CLOCK, SHIFT_CLOCK, SERIAL_IN};
			sync2_r <= sync1_r;
		end
	end

	always @(posedge MCLK) begin
		if (RESET) begin
			sclk_prev_r <= 1'b0;
			rclk_prev_r <= 1'b0;
		end else begin
			sclk_prev_r <= sync2_r[`SPL_PIN_SCLK];
			rclk_prev_r <= sync2_r[`SPL_PIN_RCLK];
		end
	end

	// same rise test on both pin clocks, kept in one place
	function rise_of;
		input now_lvl;
		input was_lvl;
		begin
			rise_of = now_lvl & ~was_lvl;
		end
	endfunction

	assign shift_rise = rise_of(sync2_r[`SPL_PIN_SCLK], sclk_prev_r);
	assign store_rise = rise_of(sync2_r[`SPL_PIN_RCLK], rclk_prev_r);
	assign shift_clr  = ~sync2_r[`SPL_PIN_SCLR_N];
	assign store_clr  = ~sync2_r[`SPL_PIN_STORAGE_CLEAR_N];

	// clears win over edges and touch only their own register
	always @* begin
		shift_nxt = shift_r;
		if (shift_clr)
			shift_nxt = `SPL_SHIFT_RESET;
		else if (shift_rise)
			shift_nxt = {shift_r[`SPL_WIDTH-2:0], sync2_r[`SPL_PIN_SER]};
	end

	// capture reads the pre-edge shift value, so tied clocks lag by one
	always @* begin
		store_nxt = store_r;
		if (store_clr)
			store_nxt = `SPL_STORE_RESET;
		else if (store_rise)
			store_nxt = shift_r;
	end

	always @(posedge MCLK) begin
		if (RESET) begin
			shift_r      <= `SPL_SHIFT_RESET;
			store_r      <= `SPL_STORE_RESET;
			PARALLEL_OUT <= `SPL_STORE_RESET;
			CASCADE_OUT  <= 1'b0;
		end else begin
			shift_r      <= shift_nxt;
			store_r      <= store_nxt;
			PARALLEL_OUT <= store_nxt;
			CASCADE_OUT  <= shift_nxt[`SPL_WIDTH-1];
		end
	end

	// capture log; a full log drops words, the pins cannot be stalled
	assign log_push = store_rise & ~store_clr;

	spl_fifo #(
		.WIDTH (`SPL_WIDTH),
		.DEPTH (`SPL_FIFO_DEPTH),
		.AW    (`SPL_FIFO_AW)
	) u_log (
		.clk         (MCLK),
		.rst         (RESET),
		.in_data     (shift_r),
		.in_valid    (log_push),
		.in_ready_r  (LOG_ACCEPT),
		.out_data_r  (LOG_DATA),
		.out_valid_r (LOG_VALID),
		.out_ready   (LOG_READY)
	);
endmodule

// ### spl_consts.vh
// constants for the serial-in, parallel-out shift latch
// assumes one system clock; all pins are sampled into that domain
// How it works
// - an eight-stage shift register loads one bit at a time and its whole content moves into an eight-bit storage register.
// - shift and storage stages each have their own clock and their own clear, and each clear overrides its clock and zeroes only its own register.
// - both clocks act on rising edges, the shift register advancing and the storage register capturing the shift register.
// - with both clocks tied together the storage register takes the shift value from before the edge, one pulse behind.
// - the last shift stage is driven on a cascade output that can feed the serial input of a following device.
`ifndef SPL_CONSTS_VH
`define SPL_CONSTS_VH
`define SPL_WIDTH        8
`define SPL_FIFO_DEPTH   16
`define SPL_FIFO_AW      4
`define SPL_SHIFT_RESET  8'h00
`define SPL_STORE_RESET  8'h00
`define SPL_PIN_COUNT    5
`define SPL_PIN_SER      0
`define SPL_PIN_SCLK     1
`define SPL_PIN_RCLK     2
`define SPL_PIN_SCLR_N   3
`define SPL_PIN_STORAGE_CLEAR_N   4
`define SPL_PIN_RESET    5'h18
`endif

// ### spl_fifo.v
// word fifo with a registered output stage
// assumes source and sink share the clock; sink may stall
`timescale 1ns/1ps
`include "spl_consts.vh"
module spl_fifo #(
	parameter WIDTH = `SPL_WIDTH,
	parameter DEPTH = `SPL_FIFO_DEPTH,
	parameter AW    = `SPL_FIFO_AW
) (
	input  wire             clk,
	input  wire             rst,
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output reg              in_ready_r,
	output reg  [WIDTH-1:0] out_data_r,
	output reg              out_valid_r,
	input  wire             out_ready
);
	reg  [WIDTH-1:0] mem [0:DEPTH-1];
	reg  [AW-1:0]    wr_r;
	reg  [AW-1:0]    rd_r;
	reg  [AW:0]      count_r;
	reg  [AW:0]      count_nxt;
	wire             push;
	wire             pop;
	// pop moves a word into the output stage whenever it is free
	assign push = in_valid & in_ready_r;
	assign pop  = (count_r != {(AW+1){1'b0}}) & (~out_valid_r | out_ready);

	always @* begin
		count_nxt = count_r;
		if (push & ~pop)
			count_nxt = count_r + 1'b1;
		else if (pop & ~push)
			count_nxt = count_r - 1'b1;
	end

	always @(posedge clk) begin
		if (push)
			mem[wr_r] <= in_data;
	end

	always @(posedge clk) begin
		if (rst) begin
			wr_r        <= {AW{1'b0}};
			rd_r        <= {AW{1'b0}};
			count_r     <= {(AW+1){1'b0}};
			in_ready_r  <= 1'b0;
			out_data_r  <= {WIDTH{1'b0}};
			out_valid_r <= 1'b0;
		end else begin
			count_r    <= count_nxt;
			in_ready_r <= (count_nxt < DEPTH);
			if (push)
				wr_r <= wr_r + 1'b1;
			if (pop) begin
				out_data_r  <= mem[rd_r];
				out_valid_r <= 1'b1;
				rd_r        <= rd_r + 1'b1;
			end else if (out_ready) begin
				out_valid_r <= 1'b0;
			end
		end
	end
endmodule

// ### spl_host_model.sv
// host model: serial data pin and both pin clocks
// assumes 10 MHz MCLK; every pin level held 3 cycles
`timescale 1ns/1ps
module spl_host_model (
	input  wire mclk,
	output reg  serial_in,
	output reg  sck,
	output reg  rck
);
	initial {serial_in, sck, rck} = 3'h0;
	task pulse(input reg s, input reg r);
		begin
			repeat (3) @(posedge mclk);
			#1 {sck, rck} = {s, r};
			repeat (3) @(posedge mclk);
			#1 {sck, rck} = 2'h0;
		end
	endtask
	// msb first so it ends in bit 7; data settles 3 cycles before the rise
	task send(input reg [7:0] v, input reg tie);
		integer i;
		begin
			for (i = 7; i >= 0; i = i - 1) begin
				serial_in = v[i];
				pulse(1'b1, tie);
			end
		end
	endtask
endmodule

// ### spl_shift_latch_chk.sv
// checker on the shift latch pins
// assumes pin levels last 2+ MCLK, as the sampler needs
`timescale 1ns/1ps
module spl_shift_latch_chk (
	input wire       MCLK,
	input wire       RESET,
	input wire       SHIFT_CLOCK,
	input wire       STORAGE_CLOCK,
	input wire       SHIFT_CLEAR_N,
	input wire       STORAGE_CLEAR_N,
	input wire [7:0] PARALLEL_OUT,
	input wire       CASCADE_OUT,
	input wire [7:0] LOG_DATA,
	input wire       LOG_VALID,
	input wire       LOG_READY
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (RESET);
	sequence s_shift_idle; (SHIFT_CLEAR_N && !SHIFT_CLOCK)[*6]; endsequence
	sequence s_store_idle; (STORAGE_CLEAR_N && !STORAGE_CLOCK)[*6]; endsequence
	chk_shift_clear: assert property ((!SHIFT_CLEAR_N)[*4] |-> !CASCADE_OUT)
		else $error("cascade not cleared");
	chk_store_clear: assert property ((!STORAGE_CLEAR_N)[*4] |-> PARALLEL_OUT == 8'h00)
		else $error("storage not cleared");
	chk_shift_hold: assert property (s_shift_idle |=> $stable(CASCADE_OUT))
		else $error("cascade moved without edge");
	chk_store_hold: assert property (s_store_idle |=> $stable(PARALLEL_OUT))
		else $error("storage moved without edge");
	chk_reset_zero: assert property (disable iff (1'b0) RESET |=> PARALLEL_OUT == 8'h00)
		else $error("storage not zero after reset");
	chk_reset_cas: assert property (disable iff (1'b0) RESET |=> !CASCADE_OUT)
		else $error("cascade not zero after reset");
	chk_log_hold: assert property (LOG_VALID && !LOG_READY |=> LOG_VALID && $stable(LOG_DATA))
		else $error("log word lost while stalled");
endmodule
bind spl_shift_latch spl_shift_latch_chk spl_shift_latch_chk_i (.MCLK(MCLK), .RESET(RESET),
	.SHIFT_CLOCK(SHIFT_CLOCK), .STORAGE_CLOCK(STORAGE_CLOCK), .SHIFT_CLEAR_N(SHIFT_CLEAR_N),
	.STORAGE_CLEAR_N(STORAGE_CLEAR_N), .PARALLEL_OUT(PARALLEL_OUT), .CASCADE_OUT(CASCADE_OUT),
	.LOG_DATA(LOG_DATA), .LOG_VALID(LOG_VALID), .LOG_READY(LOG_READY));

// ### spl_shift_latch_tb_top.sv
// bench: shift, tied clocks, log fill and drain, clears
// assumes spl_host_model drives serial data and pin clocks
`timescale 1ns/1ps
module spl_shift_latch_tb_top;
	reg        mclk = 1'b0;
	reg        rst = 1'b1;
	reg        sclr_n = 1'b1;
	reg        storage_clear_n = 1'b1;
	reg        ready = 1'b0;
	wire       serial_in, sck, rck, cas, lv, acc;
	wire [7:0] po, ld;
	integer    bad_count = 0;
	integer    samples_checked = 0;
	integer    n, k;
	always #50 mclk = ~mclk;
	spl_host_model spl_host_model_i (.mclk(mclk), .serial_in(serial_in), .sck(sck), .rck(rck));
	spl_shift_latch spl_shift_latch_i (.MCLK(mclk), .RESET(rst), .SERIAL_IN(serial_in),
		.SHIFT_CLOCK(sck), .STORAGE_CLOCK(rck), .SHIFT_CLEAR_N(sclr_n),
		.STORAGE_CLEAR_N(storage_clear_n), .PARALLEL_OUT(po), .CASCADE_OUT(cas), .LOG_DATA(ld),
		.LOG_VALID(lv), .LOG_READY(ready), .LOG_ACCEPT(acc));
	task settle;
		begin
			repeat (4) @(posedge mclk);
			#1;
		end
	endtask
	task cmp(input reg [8:0] got, input reg [8:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("[FAIL] %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task end_sim;
		begin
			$display("checks %0d mismatches %0d", samples_checked, bad_count);
			if (bad_count == 0 && samples_checked > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	// word j of the log: A5, then the tied-clock lagging captures of 3C, then 3C
	function [7:0] log_exp(input integer j);
		begin
			if (j == 0)
				log_exp = 8'hA5;
			else if (j < 9)
				log_exp = 8'h3C >> (9 - j);
			else
				log_exp = 8'h3C;
		end
	endfunction
	task test_reset;
		begin
			settle;
			cmp({cas, po}, 9'h000);
			cmp({7'h00, lv, acc}, 9'h001);
			$display("reset test done");
		end
	endtask
	task test_shift;
		begin
			spl_host_model_i.send(8'hA5, 1'b0);
			settle;
			cmp({cas, po}, 9'h100);
			spl_host_model_i.pulse(1'b0, 1'b1);
			settle;
			cmp({cas, po}, 9'h1A5);
			cmp({lv, ld}, 9'h1A5);
			$display("shift test done");
		end
	endtask
	task test_shift_clear;
		begin
			sclr_n = 1'b0;
			settle;
			sclr_n = 1'b1;
			settle;
			cmp({cas, po}, 9'h0A5);
			$display("shift clear test done");
		end
	endtask
	// tied clocks: storage trails by one edge
	task test_tied;
		begin
			spl_host_model_i.send(8'h3C, 1'b1);
			settle;
			cmp({cas, po}, 9'h01E);
			$display("tied test done");
		end
	endtask
	// 16 fifo words plus the output stage; the ninth storage edge is dropped
	task test_log;
		begin
			for (n = 0; n < 9; n = n + 1)
				spl_host_model_i.pulse(1'b0, 1'b1);
			settle;
			cmp({acc, po}, 9'h03C);
			ready = 1'b1;
			k = 0;
			for (n = 0; n < 40; n = n + 1) begin
				if (lv) begin
					cmp({1'b0, ld}, {1'b0, log_exp(k)});
					k = k + 1;
				end
				@(posedge mclk);
				#1;
			end
			cmp(k[8:0], 9'h011);
			cmp({7'h00, lv, acc}, 9'h001);
			$display("log test done");
		end
	endtask
	task test_store_clear;
		begin
			storage_clear_n = 1'b0;
			spl_host_model_i.pulse(1'b0, 1'b1);
			settle;
			cmp(po, 9'h000);
			storage_clear_n = 1'b1;
			spl_host_model_i.pulse(1'b0, 1'b1);
			settle;
			cmp({cas, po}, 9'h03C);
			$display("store clear test done");
		end
	endtask
	initial begin
		repeat (2) @(posedge mclk);
		#1 rst = 1'b0;
		test_reset;
		test_shift;
		test_shift_clear;
		test_tied;
		test_log;
		test_store_clear;
		end_sim;
	end
endmodule
